/* File: logic/flash_iap_params.svh */
`ifndef FLASH_IAP_PARAMS_SVH
`define FLASH_IAP_PARAMS_SVH

// register byte offsets, one 32-bit word each, data in bits 7:0
`define OFF_CTRL      8'h00
`define OFF_CLEAR     8'h04
`define OFF_ADDR_LOW  8'h08
`define OFF_ADDR_HIGH 8'h0C
`define OFF_DATA_LOW  8'h10
`define OFF_DATA_HIGH 8'h14
`define OFF_KEY_BASE  8'h18
`define KEY_COUNT     6

// control register fields
`define B_READ_START  0
`define B_READ_EN     1
`define B_EW_START    2
`define B_UNLOCK      3
`define F_MODE_LSB    4
`define F_MODE_MSB    6
`define B_EW_FLAG     7
`define B_CLEAR       0

// operation-select codes
`define MODE_WRITE    3'h0
`define MODE_ERASE    3'h1
`define MODE_READ     3'h3
`define MODE_UNLOCK   3'h6

// unlock key in register order: key1 low, key1 high, key2 low ...
`define KEY_1L        8'h00
`define KEY_1H        8'h04
`define KEY_2L        8'h0D
`define KEY_2H        8'h09
`define KEY_3L        8'hC3
`define KEY_3H        8'h40

// reset values
`define CTRL_RST      8'h00
`define BYTE_RST      8'h00
`define ERASED_WORD   16'h0000

// geometry
`define FLASH_ADDR_W  13
`define PAGE_WORDS    32

// timing
`define CLK_FREQ_HZ   40000000
`define PROG_TIME_US  2200
`define PROG_CYCLES   (`PROG_TIME_US * (`CLK_FREQ_HZ / 1000000))
`define READ_INSTR_CYCLES 3
`define CLKS_PER_INSTR 1
`define UNLOCK_CYCLES 64

`endif

/* File: logic/flash_iap_pkg.sv */
package flash_iap_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b10,
    ST_READ  = 2'b11
  } op_state_e;

  typedef logic [15:0] word_t;

endpackage

/* File: logic/write_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_iap_params.svh"

module write_buffer #(
  parameter int WORDS = `PAGE_WORDS,
  parameter int IDX_W = $clog2(`PAGE_WORDS)
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 clear,
  input  wire logic                 load,
  input  wire logic [IDX_W-1:0]     idx,
  input  wire flash_iap_pkg::word_t wdata,
  output logic      [WORDS*16-1:0]  data_flat,
  output logic      [WORDS-1:0]     valid
);

  flash_iap_pkg::word_t mem [0:WORDS-1];

  // data words need no reset, the valid bits decide what is programmed
  always_ff @(posedge clk) begin
    if (load) begin
      mem[idx] <= wdata;
    end
  end

  // clear empties the buffer in one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid <= '0;
    end else if (clear) begin
      valid <= '0;
    end else if (load) begin
      valid[idx] <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_flat
      assign data_flat[g*16 +: 16] = mem[g];
    end
  endgenerate

endmodule
`default_nettype wire

/* File: logic/flash_array.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_iap_params.svh"

module flash_array #(
  parameter int ADDR_W = `FLASH_ADDR_W,
  parameter int WORDS  = `PAGE_WORDS,
  parameter int PAGE_W = $clog2(`PAGE_WORDS)
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       erase,
  input  wire logic                       prog,
  input  wire logic [ADDR_W-PAGE_W-1:0]   page,
  input  wire logic [WORDS*16-1:0]        buf_flat,
  input  wire logic [WORDS-1:0]           buf_valid,
  input  wire logic                       rd_en,
  input  wire logic [ADDR_W-1:0]          rd_addr,
  output flash_iap_pkg::word_t            rd_data
);

  flash_iap_pkg::word_t mem [0:(1<<ADDR_W)-1];

  // erase blanks a whole page; program writes only loaded words,
  // so a reload after a failed verify needs no second erase
  always_ff @(posedge clk) begin
    for (int i = 0; i < WORDS; i++) begin
      if (erase) begin
        mem[{page, PAGE_W'(i)}] <= `ERASED_WORD;
      end else if (prog && buf_valid[i]) begin
        mem[{page, PAGE_W'(i)}] <= buf_flat[i*16 +: 16];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

/* File: logic/flash_iap_erase_write_read.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_iap_params.svh"

module flash_iap_erase_write_read #(
  parameter int ADDR_W         = `FLASH_ADDR_W,
  parameter int PROG_CYCLES    = `PROG_CYCLES,
  parameter int UNLOCK_CYCLES  = `UNLOCK_CYCLES,
  parameter int CLKS_PER_INSTR = `CLKS_PER_INSTR
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             cpu_stall
);

  localparam int PAGE_W      = $clog2(`PAGE_WORDS);
  localparam int READ_CYCLES = `READ_INSTR_CYCLES * CLKS_PER_INSTR;
  localparam int CNT_W       = $clog2(PROG_CYCLES + 1);
  localparam int UCNT_W      = $clog2(UNLOCK_CYCLES + 1);
  localparam logic [7:0] KEY_EXP [0:`KEY_COUNT-1] =
    '{`KEY_1L, `KEY_1H, `KEY_2L, `KEY_2H, `KEY_3L, `KEY_3H};

  // word decode of a byte address, low two bits ignored
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  logic                     ack_reg;
  logic [31:0]              rdat_reg;
  logic [31:0]              rdat_next;
  logic [2:0]               mode_reg;
  logic                     rd_en_reg;
  logic                     rd_start_reg;
  logic                     ew_start_reg;
  logic                     unl_start_reg;
  logic                     flag_reg;
  logic                     wbc_reg;
  logic                     stall_reg;
  logic [7:0]               addr_lo_reg;
  logic [7:0]               addr_hi_reg;
  logic [7:0]               dat_lo_reg;
  logic [7:0]               dat_hi_reg;
  logic [7:0]               key_reg [0:`KEY_COUNT-1];
  logic [PAGE_W-1:0]        idx_reg;
  logic [CNT_W-1:0]         cnt_reg;
  logic [UCNT_W-1:0]        ucnt_reg;
  flash_iap_pkg::op_state_e state_reg;
  flash_iap_pkg::word_t     rd_word;
  logic [ADDR_W-1:0]        flash_addr;
  logic [`PAGE_WORDS*16-1:0] buf_flat;
  logic [`PAGE_WORDS-1:0]   buf_valid;
  logic                     req;
  logic                     wr;
  logic                     wr_ctrl;
  logic                     wr_clear;
  logic                     wr_alo;
  logic                     wr_ahi;
  logic                     wr_dlo;
  logic                     wr_dhi;
  logic                     busy;
  logic                     ctrl_ok;
  logic [2:0]               mode_new;
  logic                     go_erase;
  logic                     go_prog;
  logic                     go_read;
  logic                     go_unlock;
  logic                     op_last;
  logic                     rd_last;
  logic                     erase_done;
  logic                     prog_done;
  logic                     read_done;
  logic                     ul_last;
  logic                     key_ok;
  logic                     load;

  // request decode; ack_reg blocks a second take of the same request
  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl  = wr & hit(wb_adr_i, `OFF_CTRL);
  assign wr_clear = wr & hit(wb_adr_i, `OFF_CLEAR);
  assign wr_alo   = wr & hit(wb_adr_i, `OFF_ADDR_LOW);
  assign wr_ahi   = wr & hit(wb_adr_i, `OFF_ADDR_HIGH);
  assign wr_dlo   = wr & hit(wb_adr_i, `OFF_DATA_LOW);
  assign wr_dhi   = wr & hit(wb_adr_i, `OFF_DATA_HIGH);

  assign busy       = (state_reg != flash_iap_pkg::ST_IDLE);
  assign flash_addr = ADDR_W'({addr_hi_reg, addr_lo_reg});

  // control writes other than a flag clear are ignored while an operation owns the block
  assign ctrl_ok  = wr_ctrl & ~busy;
  assign mode_new = wb_dat_i[`F_MODE_MSB:`F_MODE_LSB];

  // start decode; erase and write are refused without the flag
  assign go_erase  = ctrl_ok & wb_dat_i[`B_EW_START] & flag_reg
                     & (mode_new == `MODE_ERASE);
  assign go_prog   = ctrl_ok & wb_dat_i[`B_EW_START] & flag_reg
                     & (mode_new == `MODE_WRITE);
  assign go_read   = ctrl_ok & wb_dat_i[`B_READ_START] & wb_dat_i[`B_READ_EN]
                     & (mode_new == `MODE_READ);
  assign go_unlock = ctrl_ok & wb_dat_i[`B_UNLOCK] & ~unl_start_reg
                     & (mode_new == `MODE_UNLOCK);

  // completion strobes
  assign op_last    = (cnt_reg == CNT_W'(PROG_CYCLES - 1));
  assign rd_last    = (cnt_reg == CNT_W'(READ_CYCLES - 1));
  assign erase_done = (state_reg == flash_iap_pkg::ST_ERASE) & op_last;
  assign prog_done  = (state_reg == flash_iap_pkg::ST_PROG) & op_last;
  assign read_done  = (state_reg == flash_iap_pkg::ST_READ) & rd_last;
  assign ul_last    = unl_start_reg & (ucnt_reg == UCNT_W'(UNLOCK_CYCLES - 1));

  // loading is only meaningful in write mode
  assign load = wr_dhi & ~busy & (mode_reg == `MODE_WRITE);

  // key compare over all six key registers
  always_comb begin
    key_ok = 1'b1;
    for (int i = 0; i < `KEY_COUNT; i++) begin
      if (key_reg[i] != KEY_EXP[i]) begin
        key_ok = 1'b0;
      end
    end
  end

  // read mux; unmapped words answer zero
  always_comb begin
    rdat_next = 32'h0000_0000;
    if (hit(wb_adr_i, `OFF_CTRL)) begin
      rdat_next[7:0] = {flag_reg, mode_reg, unl_start_reg, ew_start_reg,
                        rd_en_reg, rd_start_reg};
    end else if (hit(wb_adr_i, `OFF_CLEAR)) begin
      rdat_next[`B_CLEAR] = wbc_reg;
    end else if (hit(wb_adr_i, `OFF_ADDR_LOW)) begin
      rdat_next[7:0] = addr_lo_reg;
    end else if (hit(wb_adr_i, `OFF_ADDR_HIGH)) begin
      rdat_next[7:0] = addr_hi_reg;
    end else if (hit(wb_adr_i, `OFF_DATA_LOW)) begin
      rdat_next[7:0] = dat_lo_reg;
    end else if (hit(wb_adr_i, `OFF_DATA_HIGH)) begin
      rdat_next[7:0] = dat_hi_reg;
    end else begin
      for (int i = 0; i < `KEY_COUNT; i++) begin
        if (hit(wb_adr_i, 8'(`OFF_KEY_BASE + 4 * i))) begin
          rdat_next[7:0] = key_reg[i];
        end
      end
    end
  end

  // classic single-cycle answer: ack one cycle after the take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req) begin
        rdat_reg <= rdat_next;
      end
    end
  end

  // mode and read enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg  <= `MODE_WRITE;
      rd_en_reg <= 1'b0;
    end else if (ctrl_ok) begin
      mode_reg  <= mode_new;
      rd_en_reg <= wb_dat_i[`B_READ_EN];
    end
  end

  // erase/write start: held high until the timed operation ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ew_start_reg <= 1'b0;
    end else if (go_erase || go_prog) begin
      ew_start_reg <= 1'b1;
    end else if (erase_done || prog_done) begin
      ew_start_reg <= 1'b0;
    end
  end

  // read start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_start_reg <= 1'b0;
    end else if (go_read) begin
      rd_start_reg <= 1'b1;
    end else if (read_done) begin
      rd_start_reg <= 1'b0;
    end
  end

  // unlock start and its timer; the key is judged only at timeout
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unl_start_reg <= 1'b0;
      ucnt_reg      <= '0;
    end else if (go_unlock) begin
      unl_start_reg <= 1'b1;
      ucnt_reg      <= '0;
    end else if (ul_last) begin
      unl_start_reg <= 1'b0;
    end else if (unl_start_reg) begin
      ucnt_reg <= ucnt_reg + 1'b1;
    end
  end

  // enabled flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= 1'b0;
    end else if (ul_last && key_ok) begin
      flag_reg <= 1'b1;
    end else if (wr_ctrl && !wb_dat_i[`B_EW_FLAG]) begin
      flag_reg <= 1'b0;
    end
  end

  // buffer clear finishes in one cycle, then the bit drops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wbc_reg <= 1'b0;
    end else if (wr_clear && wb_dat_i[`B_CLEAR] && !busy) begin
      wbc_reg <= 1'b1;
    end else if (wbc_reg) begin
      wbc_reg <= 1'b0;
    end
  end

  // address pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_lo_reg <= `BYTE_RST;
      addr_hi_reg <= `BYTE_RST;
    end else begin
      if (wr_alo) begin
        addr_lo_reg <= wb_dat_i[7:0];
      end
      if (wr_ahi) begin
        addr_hi_reg <= wb_dat_i[7:0];
      end
    end
  end

  // data pair; a finished read overwrites both, the cpu is stalled then
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dat_lo_reg <= `BYTE_RST;
      dat_hi_reg <= `BYTE_RST;
    end else if (read_done) begin
      {dat_hi_reg, dat_lo_reg} <= rd_word;
    end else begin
      if (wr_dlo) begin
        dat_lo_reg <= wb_dat_i[7:0];
      end
      if (wr_dhi) begin
        dat_hi_reg <= wb_dat_i[7:0];
      end
    end
  end

  // key registers, one word each from the key base upward
  genvar g;
  generate
    for (g = 0; g < `KEY_COUNT; g++) begin : g_key
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          key_reg[g] <= `BYTE_RST;
        end else if (wr && hit(wb_adr_i, 8'(`OFF_KEY_BASE + 4 * g))) begin
          key_reg[g] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate

  // buffer index follows the low address; stops at the page end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_reg <= '0;
    end else if (wr_alo) begin
      idx_reg <= wb_dat_i[PAGE_W-1:0];
    end else if (load && (idx_reg != {PAGE_W{1'b1}})) begin
      idx_reg <= idx_reg + 1'b1;
    end
  end

  // sequencer and its shared cycle counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= flash_iap_pkg::ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        flash_iap_pkg::ST_IDLE: begin
          cnt_reg <= '0;
          if (go_erase) begin
            state_reg <= flash_iap_pkg::ST_ERASE;
          end else if (go_prog) begin
            state_reg <= flash_iap_pkg::ST_PROG;
          end else if (go_read) begin
            state_reg <= flash_iap_pkg::ST_READ;
          end
        end
        flash_iap_pkg::ST_ERASE,
        flash_iap_pkg::ST_PROG: begin
          if (op_last) begin
            state_reg <= flash_iap_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        flash_iap_pkg::ST_READ: begin
          if (rd_last) begin
            state_reg <= flash_iap_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= flash_iap_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // cpu stall tracks any running erase, write or read, not the unlock timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stall_reg <= 1'b0;
    end else if (go_erase || go_prog || go_read) begin
      stall_reg <= 1'b1;
    end else if (erase_done || prog_done || read_done) begin
      stall_reg <= 1'b0;
    end
  end

  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = rdat_reg;
  assign cpu_stall = stall_reg;

  write_buffer #(
    .WORDS (`PAGE_WORDS),
    .IDX_W (PAGE_W)
  ) u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .clear     (wbc_reg),
    .load      (load),
    .idx       (idx_reg),
    .wdata     ({wb_dat_i[7:0], dat_lo_reg}),
    .data_flat (buf_flat),
    .valid     (buf_valid)
  );

  // array erases and programs on the last counted cycle of an operation; it reads on go_read
  flash_array #(
    .ADDR_W (ADDR_W),
    .WORDS  (`PAGE_WORDS),
    .PAGE_W (PAGE_W)
  ) u_array (
    .clk       (clk),
    .rstn      (rstn),
    .erase     (erase_done),
    .prog      (prog_done),
    .page      (flash_addr[ADDR_W-1:PAGE_W]),
    .buf_flat  (buf_flat),
    .buf_valid (buf_valid),
    .rd_en     (go_read),
    .rd_addr   (flash_addr),
    .rd_data   (rd_word)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_read_go;
    go_read ##1 rd_start_reg;
  endsequence

  sequence s_read_end;
    ##[1:8] (!rd_start_reg && !cpu_stall);
  endsequence

  property p_stall_on_ew;
    (go_erase || go_prog) |=> (cpu_stall && ew_start_reg);
  endproperty
  a_stall_on_ew: assert property (p_stall_on_ew)
    else $error("erase or write start did not stall the cpu");

  property p_ew_needs_flag;
    $rose(ew_start_reg) |-> $past(flag_reg);
  endproperty
  a_ew_needs_flag: assert property (p_ew_needs_flag)
    else $error("erase or write started while locked");

  property p_ew_held;
    (busy && state_reg != flash_iap_pkg::ST_READ && !op_last) |=> ew_start_reg;
  endproperty
  a_ew_held: assert property (p_ew_held)
    else $error("start bit dropped before the operation ended");

  property p_ew_ends;
    (erase_done || prog_done) |=> (!ew_start_reg && !cpu_stall && !busy);
  endproperty
  a_ew_ends: assert property (p_ew_ends)
    else $error("start bit or stall not released at timeout");

  property p_read_run;
    s_read_go |-> s_read_end;
  endproperty
  a_read_run: assert property (p_read_run)
    else $error("read did not complete in time");

  property p_read_data;
    read_done |=> ({dat_hi_reg, dat_lo_reg} == $past(rd_word));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read word not placed in data registers");

  property p_clear_self;
    wbc_reg |=> (!wbc_reg && buf_valid == '0);
  endproperty
  a_clear_self: assert property (p_clear_self)
    else $error("buffer clear did not finish in one cycle");

  property p_idx_step;
    (load && !wr_alo && idx_reg != {PAGE_W{1'b1}}) |=> (idx_reg == $past(idx_reg) + 1'b1);
  endproperty
  a_idx_step: assert property (p_idx_step)
    else $error("buffer index did not advance");

  property p_idx_hold;
    (load && !wr_alo && idx_reg == {PAGE_W{1'b1}}) |=> (idx_reg == {PAGE_W{1'b1}});
  endproperty
  a_idx_hold: assert property (p_idx_hold)
    else $error("buffer index wrapped at page end");

  property p_unlock_flag;
    (ul_last && !key_ok && !flag_reg) |=> (!flag_reg && !unl_start_reg);
  endproperty
  a_unlock_flag: assert property (p_unlock_flag)
    else $error("wrong key enabled erase and write");

endmodule
`default_nettype wire

/* File: testbench/firmware_host.sv */
`timescale 1ns/1ps
`default_nettype none
// firmware side of the register bus: one classic cycle at a time
module firmware_host (
  input  wire logic        clk,
  input  wire logic        ack,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [7:0]  adr,
  output logic      [3:0]  sel,
  output logic      [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end

  // request held until ack is sampled; released data goes inverted so it is never reused
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    dat <= ~dat;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/flash_iap_erase_write_read_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_iap_params.svh"
module flash_iap_erase_write_read_bench;
  localparam int PROG = 20;
  logic        clk;
  logic        rstn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        stall;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] di;
  logic [31:0] dout;
  int          bad_count = 0;
  int          compares = 0;
  int          n = 0;
  logic [31:0] x = 32'h0000_1620;
  logic [7:0]  exp_q[$];
  int          stall_q[$];
  logic [7:0]  fl = 8'h00;
  logic [15:0] w[4];
  logic [7:0]  key[6] = '{`KEY_1L, `KEY_1H, `KEY_2L, `KEY_2H, `KEY_3L, `KEY_3H};

  flash_iap_erase_write_read #(.PROG_CYCLES(PROG), .UNLOCK_CYCLES(40), .CLKS_PER_INSTR(1)) DUT (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack), .cpu_stall(stall));

  firmware_host h (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat(di));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // read results are taken at the ack edge, oldest note first
  always @(posedge clk) if (ack === 1'b1 && we === 1'b0)
    check("read data", dout, {24'h000000, exp_q.pop_front()});
  // stall length counted in edges, compared when it drops
  always @(posedge clk) begin
    if (stall === 1'b1) n <= n + 1;
    else if (n != 0) begin
      check("stall cycles", n, stall_q.pop_front());
      n <= 0;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    h.bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    h.bus(1'b0, a, 8'h00);
  endtask
  task automatic op(input logic [7:0] c, input int len);
    stall_q.push_back(len);
    wr(8'h00, c);
    while (stall !== 1'b0) @(posedge clk);
  endtask
  task automatic addr(input logic [12:0] a);
    wr(8'h08, a[7:0]);
    wr(8'h0C, {3'h0, a[12:8]});
  endtask
  // word read: mode 011, enable and start in one write
  task automatic read_start(input logic [12:0] a, input logic [15:0] e);
    addr(a);
    op(fl | 8'h33, 3);
    rd(8'h10, e[7:0]);
    rd(8'h14, e[15:8]);
    rd(8'h00, fl | 8'h32);
  endtask
  // low byte first, high byte loads the buffer
  task automatic load(input int k);
    x = xs(x);
    w[k] = x[15:0];
    wr(8'h10, w[k][7:0]);
    wr(8'h14, w[k][15:8]);
  endtask

  initial begin
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'hF0, 8'h00);
    wr(8'h00, 8'h14);
    rd(8'h00, 8'h10);
    wr(8'h00, 8'h68);
    for (int i = 0; i < 6; i++) wr(8'h18 + 8'(4 * i), key[i]);
    repeat (40) @(posedge clk);
    rd(8'h00, 8'hE0);
    fl = 8'h80;
    addr(13'h003E);
    stall_q.push_back(PROG);
    wr(8'h00, 8'h94);
    rd(8'h00, 8'h94);
    while (stall !== 1'b0) @(posedge clk);
    rd(8'h00, 8'h90);
    read_start(13'h0020, 16'h0000);
    wr(8'h00, 8'h80);
    addr(13'h003E);
    for (int k = 0; k < 3; k++) load(k);
    op(8'h84, PROG);
    rd(8'h00, 8'h80);
    read_start(13'h003E, w[0]);
    read_start(13'h003F, w[2]);
    wr(8'h04, 8'h01);
    rd(8'h04, 8'h00);
    wr(8'h00, 8'h80);
    addr(13'h003F);
    load(3);
    op(8'h84, PROG);
    read_start(13'h003F, w[3]);
    fl = 8'h00;
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h14);
    rd(8'h00, 8'h10);
    read_start(13'h003F, w[3]);
    // a wrong last key byte must leave erase and write locked
    wr(8'h00, 8'h68);
    wr(8'h2C, ~key[5]);
    repeat (40) @(posedge clk);
    rd(8'h00, 8'h60);
    results();
  end

  // hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
